/* acs_defines.svh */
// offsets, field positions, reset values and timing counts of the scan sequencer
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define ACS_OFF_CONTROL 12'h000
`define ACS_OFF_TABLE_PTR 12'h004
`define ACS_OFF_REG_PTR 12'h008
`define ACS_OFF_COUNT 12'h00C
`define ACS_OFF_COMMAND 12'h010
`define ACS_OFF_RESULT 12'h014
`define ACS_OFF_TEST 12'h018
`define ACS_OFF_STATUS 12'h01C
`define ACS_OFF_TABLE_BASE 12'h400

// ----------------------------------------
// field positions
// ----------------------------------------
`define ACS_CTL_ROUTE 0
`define ACS_CTL_SERVICE 1
`define ACS_CTL_UPDATE 2
`define ACS_CMD_START 3
`define ACS_CMD_MODE4 4
`define ACS_CMD_THRESH 5
`define ACS_TEST_ENABLE 0
`define ACS_TEST_REF 1
`define ACS_TEST_OFS_UP 2
`define ACS_TEST_OFS_DN 3
`define ACS_RES_BUSY 3

// ----------------------------------------
// sequencer address space
// ----------------------------------------
`define ACS_ADDR_RESULT 16'h1FAA
`define ACS_ADDR_COMMAND 16'h1FAC

// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define ACS_RST_PTR 16'h0000
`define ACS_RST_COUNT 9'h000
`define ACS_RST_TEST 8'h00
`define ACS_MAX_COUNT 9'h100

// ----------------------------------------
// timing counts in clock cycles
// ----------------------------------------
`define ACS_BUSY_DELAY 8
`define ACS_CONV_CYCLES_10 44
`define ACS_CONV_CYCLES_8 36

`endif

/* acs_pkg.sv */
// types shared by the scan sequencer and its converter
package acs_pkg;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_MOVE, SEQ_CMD, SEQ_CLOSE} acs_seq_state_type;

    typedef enum logic [1:0] {CNV_IDLE, CNV_WAIT_TRIG, CNV_RUN} acs_cnv_state_type;

endpackage : acs_pkg

/* acs_converter.sv */
// converter model: command decode, conversion timing, threshold and test modes
`timescale 1ns/1ps
`include "acs_defines.svh"

module acs_converter
    import acs_pkg::*;
#(
    parameter int BUSY_DELAY = `ACS_BUSY_DELAY,
    parameter int CYCLES_10 = `ACS_CONV_CYCLES_10,
    parameter int CYCLES_8 = `ACS_CONV_CYCLES_8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cmd_wr,
    input wire logic [15:0] cmd_data,
    input wire logic [7:0] test_bits,
    input wire logic event_processor_start,
    input wire logic [9:0] analog_level_in,
    output logic [2:0] channel_select,
    output logic [15:0] result_word,
    output logic conv_done,
    output logic threshold_pulse
);

    acs_cnv_state_type state_reg;
    logic [9:0] level_meta_reg;
    logic [9:0] level_sync_reg;
    logic [15:0] cmd_reg;
    logic [7:0] cnt_reg;
    logic busy_reg;
    logic [9:0] sample_reg;
    logic [2:0] chan_reg;
    logic done_reg;
    logic thr_reg;
    logic thr_seen_reg;

    // ----------------------------------------
    // pin synchroniser
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_meta_reg <= 10'h000;
            level_sync_reg <= 10'h000;
        end else begin
            level_meta_reg <= analog_level_in;
            level_sync_reg <= level_meta_reg;
        end
    end

    // ----------------------------------------
    // decode and sample path
    // ----------------------------------------
    wire cmd_starts = cmd_wr && (cmd_data != 16'h0000);
    wire thresh_mode = cmd_reg[`ACS_CMD_THRESH];
    wire eight_bit = cmd_reg[`ACS_CMD_MODE4] && !thresh_mode;
    wire [7:0] conv_len = eight_bit ? 8'(CYCLES_8) : 8'(CYCLES_10);
    wire conv_end = (state_reg == CNV_RUN) && (cnt_reg == conv_len - 8'h01);
    wire [9:0] raw = test_bits[`ACS_TEST_ENABLE] ?
        (test_bits[`ACS_TEST_REF] ? 10'h3FF : 10'h000) : level_sync_reg;
    wire ofs_up = test_bits[`ACS_TEST_OFS_UP] && !test_bits[`ACS_TEST_OFS_DN];
    wire ofs_dn1 = test_bits[`ACS_TEST_OFS_DN] && !test_bits[`ACS_TEST_OFS_UP];
    wire ofs_dn2 = test_bits[`ACS_TEST_OFS_DN] && test_bits[`ACS_TEST_OFS_UP];
    // offsets saturate so a correction never wraps the code
    wire [9:0] adjusted = ofs_up ? ((raw == 10'h3FF) ? raw : raw + 10'h001) :
        ofs_dn1 ? ((raw == 10'h000) ? raw : raw - 10'h001) :
        ofs_dn2 ? ((raw < 10'h002) ? 10'h000 : raw - 10'h002) : raw;
    wire [9:0] sample = eight_bit ? {adjusted[9:2], 2'b00} : adjusted;
    wire [7:0] level_hi = sample[9:2];
    wire crossed = cmd_reg[`ACS_CMD_MODE4] ? (level_hi < cmd_reg[15:8]) :
        (level_hi > cmd_reg[15:8]);

    // ----------------------------------------
    // conversion state machine
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= CNV_IDLE;
            cmd_reg <= 16'h0000;
            cnt_reg <= 8'h00;
            busy_reg <= 1'b0;
        end else if (cmd_wr) begin
            // a new command aborts whatever runs
            cmd_reg <= cmd_data;
            cnt_reg <= 8'h00;
            busy_reg <= 1'b0;
            if (!cmd_starts) begin
                state_reg <= CNV_IDLE;
            end else if (cmd_data[`ACS_CMD_START]) begin
                state_reg <= CNV_RUN;
            end else begin
                state_reg <= CNV_WAIT_TRIG;
            end
        end else begin
            case (state_reg)
                CNV_WAIT_TRIG: begin
                    if (event_processor_start) begin
                        state_reg <= CNV_RUN;
                    end
                end
                CNV_RUN: begin
                    cnt_reg <= conv_end ? 8'h00 : cnt_reg + 8'h01;
                    if (cnt_reg == 8'(BUSY_DELAY - 1)) begin
                        busy_reg <= 1'b1;
                    end
                    if (conv_end) begin
                        busy_reg <= 1'b0;
                        state_reg <= thresh_mode ? CNV_RUN : CNV_IDLE;
                    end
                end
                default: begin
                    state_reg <= CNV_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // results and events
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_reg <= 10'h000;
            chan_reg <= 3'h0;
            done_reg <= 1'b0;
            thr_reg <= 1'b0;
            thr_seen_reg <= 1'b0;
        end else begin
            done_reg <= conv_end && !cmd_wr && !thresh_mode;
            thr_reg <= conv_end && !cmd_wr && thresh_mode && crossed && !thr_seen_reg;
            if (cmd_wr) begin
                thr_seen_reg <= 1'b0;
            end else if (conv_end && thresh_mode) begin
                thr_seen_reg <= crossed;
            end
            if (conv_end && !cmd_wr) begin
                sample_reg <= sample;
                chan_reg <= cmd_reg[2:0];
            end
        end
    end

    assign result_word = {sample_reg, 2'b00, busy_reg, chan_reg};
    assign channel_select = cmd_reg[2:0];
    assign conv_done = done_reg;
    assign threshold_pulse = thr_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_zero_command: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd_wr && cmd_data == 16'h0000) |=> ((state_reg == CNV_IDLE) && !conv_done) [*3])
        else $error("zero command started a conversion");

    a_busy_delay: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd_wr && cmd_starts && cmd_data[`ACS_CMD_START]) ##1 !cmd_wr [*8]
        |=> busy_reg && !$past(busy_reg))
        else $error("busy bit not set eight cycles after start");

    a_abort_done: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd_wr && state_reg == CNV_RUN) |=> !conv_done)
        else $error("aborted conversion signalled done");

endmodule : acs_converter

/* acs_sequencer.sv */
// scan transfer sequencer with apb registers, command/data table and converter
// How it works
// - transfer count holds up to 256 transfers run without software between them
// - each transfer reads the table word and holds its low byte
// - table pointer advances by two after the command fetch
// - value at register pointer is stored at table pointer; register pointer advances two
// - held command byte is then written to the advanced register pointer location
// - table pointer written back only when enabled; count decrements per transfer
// - at count zero route select clears and service flag sets
// - an all-zero command never starts a conversion
// - table commands are issued in stored order, each 8-bit or 10-bit
// - threshold mode converts one channel repeatedly and flags a crossing
// - a threshold crossing raises a wake request and the converter interrupt
// - result word carries the 10-bit sample in bits 15 to 6
// - test conversions on ground or reference, with small offset correction
// - command bits choose channel, start source, threshold mode and direction or width
// - a command written mid-conversion aborts it; done waits for the new one
// - busy bit sets eight cycles after a conversion starts
`timescale 1ns/1ps
`include "acs_defines.svh"

module acs_sequencer
    import acs_pkg::*;
#(
    parameter int TABLE_WORDS = 256,
    parameter int BUSY_DELAY = `ACS_BUSY_DELAY,
    parameter int CYCLES_10 = `ACS_CONV_CYCLES_10,
    parameter int CYCLES_8 = `ACS_CONV_CYCLES_8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic event_processor_start,
    input wire logic [9:0] analog_level_in,
    output logic [2:0] analog_channel_select,
    output logic adc_interrupt,
    output logic wake_request
);

    localparam int AW = $clog2(TABLE_WORDS);

    // ----------------------------------------
    // state
    // ----------------------------------------
    acs_seq_state_type state_reg;
    logic [15:0] mem [TABLE_WORDS];
    logic sequencer_route_select_reg;
    logic sequencer_service_flag_reg;
    logic pointer_update_reg;
    logic [15:0] table_pointer_reg;
    logic [15:0] register_pointer_reg;
    logic [8:0] transfer_count_reg;
    logic [7:0] test_reg;
    logic [15:0] tp_work_reg;
    logic [15:0] rp_work_reg;
    logic [7:0] hold_reg;
    logic active_q_reg;
    logic [31:0] prdata_reg;
    logic adc_interrupt_reg;
    logic wake_request_reg;
    logic [15:0] result_word;
    logic conv_done;
    logic threshold_pulse;

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    wire [11:0] mem_off = paddr - `ACS_OFF_TABLE_BASE;
    wire aligned = (paddr[1:0] == 2'b00);
    wire hit_ctl = aligned && (paddr == `ACS_OFF_CONTROL);
    wire hit_tp = aligned && (paddr == `ACS_OFF_TABLE_PTR);
    wire hit_rp = aligned && (paddr == `ACS_OFF_REG_PTR);
    wire hit_cnt = aligned && (paddr == `ACS_OFF_COUNT);
    wire hit_cmd = aligned && (paddr == `ACS_OFF_COMMAND);
    wire hit_res = aligned && (paddr == `ACS_OFF_RESULT);
    wire hit_test = aligned && (paddr == `ACS_OFF_TEST);
    wire hit_stat = aligned && (paddr == `ACS_OFF_STATUS);
    wire hit_mem = aligned && (paddr >= `ACS_OFF_TABLE_BASE)
        && (mem_off < 12'(TABLE_WORDS * 4));
    wire hit_any = hit_ctl || hit_tp || hit_rp || hit_cnt || hit_cmd || hit_res
        || hit_test || hit_stat || hit_mem;
    wire seq_active = (state_reg != SEQ_IDLE) || active_q_reg;
    // table and command share paths with the sequencer, so they wait it out
    assign pready = !((hit_mem || hit_cmd) && seq_active);
    assign pslverr = psel && penable && !hit_any;
    wire apb_wr = psel && penable && pready && pwrite && hit_any;
    wire [AW-1:0] apb_index = mem_off[AW+1:2];

    // ----------------------------------------
    // transfer datapath
    // ----------------------------------------
    wire start = conv_done && sequencer_route_select_reg && (state_reg == SEQ_IDLE);
    wire [15:0] fetched = mem[table_pointer_reg[AW:1]];
    // only the result location is special; anything else is table memory
    wire [15:0] reg_src = (rp_work_reg == `ACS_ADDR_RESULT) ?
        result_word : mem[rp_work_reg[AW:1]];
    wire seq_cmd_wr = (state_reg == SEQ_CMD) && (rp_work_reg == `ACS_ADDR_COMMAND);
    wire seq_mem_we = (state_reg == SEQ_MOVE) || ((state_reg == SEQ_CMD) && !seq_cmd_wr);
    wire [AW-1:0] seq_index = (state_reg == SEQ_MOVE) ? tp_work_reg[AW:1] : rp_work_reg[AW:1];
    wire [15:0] seq_wdata = (state_reg == SEQ_MOVE) ? reg_src : {8'h00, hold_reg};
    wire apb_mem_we = apb_wr && hit_mem;
    wire apb_cmd_wr = apb_wr && hit_cmd;
    wire cmd_wr = seq_cmd_wr || apb_cmd_wr;
    wire [15:0] cmd_data = seq_cmd_wr ? {8'h00, hold_reg} : pwdata[15:0];
    wire last_transfer = (transfer_count_reg <= 9'h001);
    // any value beyond the maximum clamps, not just those with bit 8 set
    wire [8:0] count_wdata = (pwdata > 32'h0000_0100) ? `ACS_MAX_COUNT : pwdata[8:0];

    // ----------------------------------------
    // table memory
    // ----------------------------------------
    always_ff @(posedge pclk) begin
        if (seq_mem_we) begin
            mem[seq_index] <= seq_wdata;
        end else if (apb_mem_we) begin
            mem[apb_index] <= pwdata[15:0];
        end
    end

    // ----------------------------------------
    // sequencer state machine
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= SEQ_IDLE;
            tp_work_reg <= `ACS_RST_PTR;
            rp_work_reg <= `ACS_RST_PTR;
            hold_reg <= 8'h00;
        end else begin
            case (state_reg)
                SEQ_IDLE: begin
                    if (start) begin
                        hold_reg <= fetched[7:0];
                        tp_work_reg <= table_pointer_reg + 16'h0002;
                        rp_work_reg <= register_pointer_reg;
                        state_reg <= SEQ_MOVE;
                    end
                end
                SEQ_MOVE: begin
                    rp_work_reg <= rp_work_reg + 16'h0002;
                    state_reg <= SEQ_CMD;
                end
                SEQ_CMD: begin
                    state_reg <= SEQ_CLOSE;
                end
                default: begin
                    state_reg <= SEQ_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // software registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sequencer_route_select_reg <= 1'b0;
            pointer_update_reg <= 1'b0;
            test_reg <= `ACS_RST_TEST;
            register_pointer_reg <= `ACS_RST_PTR;
        end else begin
            if (apb_wr && hit_ctl) begin
                sequencer_route_select_reg <= pwdata[`ACS_CTL_ROUTE];
                pointer_update_reg <= pwdata[`ACS_CTL_UPDATE];
            end
            if (state_reg == SEQ_CLOSE && last_transfer) begin
                sequencer_route_select_reg <= 1'b0;
            end
            if (apb_wr && hit_test) begin
                test_reg <= pwdata[7:0];
            end
            if (apb_wr && hit_rp) begin
                register_pointer_reg <= pwdata[15:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            table_pointer_reg <= `ACS_RST_PTR;
            transfer_count_reg <= `ACS_RST_COUNT;
            sequencer_service_flag_reg <= 1'b0;
        end else begin
            if (state_reg == SEQ_CLOSE && pointer_update_reg) begin
                // store auto-increments too, so the next fetch lands on a command
                table_pointer_reg <= tp_work_reg + 16'h0002;
            end else if (apb_wr && hit_tp) begin
                table_pointer_reg <= pwdata[15:0];
            end
            if (state_reg == SEQ_CLOSE) begin
                transfer_count_reg <= transfer_count_reg - 9'h001;
            end else if (apb_wr && hit_cnt) begin
                transfer_count_reg <= count_wdata;
            end
            // hardware set wins over a software clear in the same cycle
            if (state_reg == SEQ_CLOSE && last_transfer) begin
                sequencer_service_flag_reg <= 1'b1;
            end else if (apb_wr && hit_ctl && pwdata[`ACS_CTL_SERVICE]) begin
                sequencer_service_flag_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // read data and event outputs
    // ----------------------------------------
    wire [31:0] ctl_word = {29'h0, pointer_update_reg, sequencer_service_flag_reg,
        sequencer_route_select_reg};
    wire [31:0] rd_mux = hit_ctl ? ctl_word :
        hit_tp ? {16'h0000, table_pointer_reg} :
        hit_rp ? {16'h0000, register_pointer_reg} :
        hit_cnt ? {23'h0, transfer_count_reg} :
        hit_res ? {16'h0000, result_word} :
        hit_test ? {24'h0, test_reg} :
        hit_stat ? {30'h0, result_word[`ACS_RES_BUSY], seq_active} :
        hit_mem ? {16'h0000, mem[apb_index]} : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
            active_q_reg <= 1'b0;
            adc_interrupt_reg <= 1'b0;
            wake_request_reg <= 1'b0;
        end else begin
            prdata_reg <= psel ? rd_mux : prdata_reg;
            active_q_reg <= (state_reg != SEQ_IDLE);
            adc_interrupt_reg <= (conv_done && !sequencer_route_select_reg)
                || threshold_pulse;
            wake_request_reg <= threshold_pulse;
        end
    end

    assign prdata = prdata_reg;
    assign adc_interrupt = adc_interrupt_reg;
    assign wake_request = wake_request_reg;

    // ----------------------------------------
    // converter
    // ----------------------------------------
    acs_converter #(
        .BUSY_DELAY(BUSY_DELAY),
        .CYCLES_10(CYCLES_10),
        .CYCLES_8(CYCLES_8)
    ) u_converter (
        .pclk(pclk),
        .presetn(presetn),
        .cmd_wr(cmd_wr),
        .cmd_data(cmd_data),
        .test_bits(test_reg),
        .event_processor_start(event_processor_start),
        .analog_level_in(analog_level_in),
        .channel_select(analog_channel_select),
        .result_word(result_word),
        .conv_done(conv_done),
        .threshold_pulse(threshold_pulse)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_hold_fetch: assert property (@(posedge pclk) disable iff (!presetn)
        start |=> hold_reg == $past(fetched[7:0]))
        else $error("held command byte differs from fetched word");

    a_table_advance: assert property (@(posedge pclk) disable iff (!presetn)
        start |=> tp_work_reg == $past(table_pointer_reg) + 16'h0002)
        else $error("table pointer not advanced by two");

    a_reg_advance: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == SEQ_MOVE) |=> rp_work_reg == $past(rp_work_reg) + 16'h0002)
        else $error("register pointer not advanced by two");

    a_cmd_last: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == SEQ_CMD && rp_work_reg == `ACS_ADDR_COMMAND)
        |-> cmd_wr && cmd_data == {8'h00, hold_reg})
        else $error("held command not written to command location");

    a_count_dec: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == SEQ_CLOSE) |=> transfer_count_reg == $past(transfer_count_reg) - 9'h001)
        else $error("transfer count not decremented");

    a_scan_end: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == SEQ_CLOSE && last_transfer)
        |=> !sequencer_route_select_reg && sequencer_service_flag_reg)
        else $error("end of scan did not clear route and set service");

    a_one_transfer: assert property (@(posedge pclk) disable iff (!presetn)
        start |=> (state_reg == SEQ_MOVE) ##1 (state_reg == SEQ_CMD)
        ##1 (state_reg == SEQ_CLOSE) ##1 (state_reg == SEQ_IDLE))
        else $error("transfer sequence broken");

    a_wake_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        threshold_pulse |=> wake_request && adc_interrupt)
        else $error("threshold crossing did not wake");

endmodule : acs_sequencer

/* acs_analog_src.sv */
// far-side model: analog input level and event processor start
`timescale 1ns/1ps

module acs_analog_src (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [9:0] level_set,
    input wire logic trig,
    output logic [9:0] analog_level_in,
    output logic event_processor_start
);
    // ----------------------------------------
    // registered pin drive
    // ----------------------------------------
    // level held steady so a sample never straddles a change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_level_in <= 10'h000;
            event_processor_start <= 1'b0;
        end else begin
            analog_level_in <= level_set;
            event_processor_start <= trig;
        end
    end
endmodule : acs_analog_src

/* acs_sequencer_tb_top.sv */
// self-checking bench of the scan transfer sequencer
`timescale 1ns/1ps
`include "acs_defines.svh"

module acs_sequencer_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic trig = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic [31:0] seed;
    logic [9:0] lvl = 10'h000;
    logic [9:0] ain;
    logic pready, pslverr, eps, err;
    logic [2:0] chs;
    logic irq, wake;
    int fail_count = 0;
    int n_tests = 0;
    logic [31:0] exp_q[$];
    logic [31:0] n_wake = 32'h0;
    logic [31:0] n_irq = 32'h0;

    always #2 pclk = ~pclk;

    // one-cycle pulses are counted so no check can miss them
    always @(posedge pclk) begin
        n_wake <= n_wake + 32'(wake);
        n_irq <= n_irq + 32'(irq);
    end

    acs_analog_src src (.pclk(pclk), .presetn(presetn), .level_set(lvl), .trig(trig),
        .analog_level_in(ain), .event_processor_start(eps));
    acs_sequencer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .event_processor_start(eps), .analog_level_in(ain),
        .analog_channel_select(chs), .adc_interrupt(irq), .wake_request(wake));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    // ----------------------------------------
    // apb master and compare
    // ----------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic end_sim;
        $display("compares %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    initial begin
        #200000;
        fail_count++;
        end_sim;
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        seed = xs(32'd60082);
        lvl = seed[9:0];
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `ACS_OFF_COUNT, 32'h0);
        cmp(rd, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        cmp({rd[30:0], err}, 32'h1);
        $display("test reset and unmapped done");
        // table: 8-bit command on ch1, then the all-zero stop word
        apb(1'b1, `ACS_OFF_TABLE_BASE, 32'h19);
        apb(1'b1, `ACS_OFF_TABLE_BASE + 12'h8, 32'h0);
        apb(1'b1, `ACS_OFF_TABLE_PTR, 32'h0);
        apb(1'b1, `ACS_OFF_REG_PTR, {16'h0, `ACS_ADDR_RESULT});
        apb(1'b1, `ACS_OFF_COUNT, 32'h2);
        apb(1'b1, `ACS_OFF_CONTROL, 32'h5);
        apb(1'b1, `ACS_OFF_COMMAND, 32'h0B);
        exp_q.push_back({16'h0, lvl, 6'h03});
        exp_q.push_back({16'h0, lvl[9:2], 2'b00, 6'h01});
        for (int i = 0; i < 400 && rd[1] !== 1'b1; i++) begin
            apb(1'b0, `ACS_OFF_CONTROL, 32'h0);
        end
        cmp(rd & 32'h3, 32'h2);
        apb(1'b0, `ACS_OFF_COUNT, 32'h0);
        cmp(rd, 32'h0);
        apb(1'b0, `ACS_OFF_TABLE_PTR, 32'h0);
        cmp(rd, 32'h8);
        for (int i = 0; i < 2; i++) begin
            apb(1'b0, `ACS_OFF_TABLE_BASE + 12'h4 + 12'(8 * i), 32'h0);
            cmp(rd & ~32'h38, exp_q.pop_front());
        end
        repeat (60) @(posedge pclk);
        apb(1'b0, `ACS_OFF_STATUS, 32'h0);
        cmp(rd & 32'h3, 32'h0);
        cmp(n_irq, 32'h0);
        $display("test scan done");
        // threshold on the reference input, minus one code, started by the event processor
        apb(1'b1, `ACS_OFF_TEST, 32'hB);
        apb(1'b1, `ACS_OFF_COMMAND, 32'h8027);
        @(posedge pclk);
        trig <= 1'b1;
        cmp({29'h0, chs}, 32'h7);
        @(posedge pclk);
        trig <= 1'b0;
        repeat (120) @(posedge pclk);
        cmp(n_wake, 32'h1);
        cmp(n_irq, 32'h1);
        apb(1'b1, `ACS_OFF_COMMAND, 32'h0);
        apb(1'b1, `ACS_OFF_COMMAND, 32'h0F);
        repeat (60) @(posedge pclk);
        cmp(n_irq, 32'h2);
        apb(1'b0, `ACS_OFF_RESULT, 32'h0);
        cmp(rd & ~32'h38, 32'hFF87);
        $display("test threshold and test modes done");
        end_sim;
    end
endmodule : acs_sequencer_tb_top
